// ### rtl/cp_port_cfg.svh
// Constants for the core-side coprocessor handshake port.
// Assumes inclusion by the package, the port module, the model and the bench.
`ifndef CP_PORT_CFG_SVH
`define CP_PORT_CFG_SVH
`define HS_ABSENT 2'b10
`define HS_WAIT 2'b00
`define HS_GO 2'b01
`define HS_LAST 2'b11
`define SYSCTL_CP_NUM 4'hf
`define DATA_W 32
`endif

// ### rtl/cp_port_pkg.sv
// Types for the core-side coprocessor handshake port.
// Assumes cp_port_cfg.svh is on the include path.
`include "cp_port_cfg.svh"
package cp_port_pkg;
    typedef logic [1:0] handshake_t;
    typedef enum logic [2:0]
    {
        OP_TO_CP,
        OP_FROM_CP,
        OP_PAIR_TO_CP,
        OP_PAIR_FROM_CP,
        OP_DATA_OP
    } cp_op_e;
endpackage : cp_port_pkg

// ### rtl/coprocessor_handshake_port.sv
// Core-side sequencer for the coprocessor handshake port.
// Assumes the core pipeline offers one instruction at a time on the issue port,
// and that handshake inputs come from coprocessor logic on the same clock.
//
// Operation
// - Handshakes encode ABSENT 10, WAIT 00, GO 01, LAST 11.
// - Advance marks instruction entering Decode; coprocessor answers on decode handshake.
// - Next advance issues to Execute; pass raised, decode handshake sampled if passing.
// - Later Execute cycles sample execute handshake; LAST commits single transfers.
// - Move-to drives write data; move-from samples read data at end of Memory stage.
// - Pair-to drives first word in second Execute, second word in Memory.
// - Pair-from samples read data ending second Execute and first Memory.
// - Unready source data interlocks; coprocessor holds instruction in Decode.
// - Abort in cycle after Execute makes coprocessor discard the instruction.
// - Only the decode handshake at Execute entry counts.
// - Pass drops on interrupt during busy-wait; coprocessor abandons.
// - Move-to system control coprocessor drives data on both address buses on GO.
// - No coprocessor: handshakes tied ABSENT, pass and abort unconnected.
// - Undefined or unaccepted coprocessor instructions take the undefined trap.
// - Abort valid the cycle after first Execute; may assert without instruction.
`timescale 1ns/1ps
`include "cp_port_cfg.svh"
module coprocessor_handshake_port
    import cp_port_pkg::*;
#(
    parameter int DataW = `DATA_W
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clock_gate_enable,
    input wire logic issueValid,
    input wire cp_port_pkg::cp_op_e issueOp,
    input wire logic [3:0] issueCpNum,
    input wire logic issueCondPass,
    input wire logic issueSrcReady,
    input wire logic [DataW-1:0] issueSrcA,
    input wire logic [DataW-1:0] issueSrcB,
    input wire logic archUndefined,
    input wire logic interruptReq,
    input wire logic abortReq,
    input wire cp_port_pkg::handshake_t decode_handshake,
    input wire cp_port_pkg::handshake_t execute_handshake,
    input wire logic [DataW-1:0] read_data_bus,
    output logic pipeline_advance,
    output logic condition_passed,
    output logic abort_pending_cp,
    output logic [DataW-1:0] write_data_bus,
    output logic [DataW-1:0] fetch_addr_bus,
    output logic [DataW-1:0] operand_addr_bus,
    output logic undefTrap,
    output logic cpBusy,
    output logic resultValid,
    output logic resultPair,
    output logic [DataW-1:0] resultLo,
    output logic [DataW-1:0] resultHi
);
    import cp_port_pkg::*;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    typedef enum {IDLE, DECODE, EXEC, FINAL, MEM1, MEM2} seq_e;
    seq_e state_q;
    cp_op_e op_q;
    logic [3:0] cpNum_q;
    logic [DataW-1:0] srcA_q;
    logic [DataW-1:0] srcB_q;
    logic [DataW-1:0] rdLo_q;
    logic [DataW-1:0] rdHi_q;
    logic passExec;
    logic isTo;
    logic stepOk;
    logic decRefused_q;

    assign isTo = (op_q == OP_TO_CP) || (op_q == OP_PAIR_TO_CP);
    // Interlock stalls Execute entry until source data is ready
    assign stepOk = clock_gate_enable && (!isTo || issueSrcReady);

    // Advance pulses for Decode entry and Execute issue only
    always_comb
    begin
        pipeline_advance = 1'b0;
        unique case (state_q)
            IDLE: pipeline_advance = clock_gate_enable && issueValid;
            DECODE: pipeline_advance = stepOk;
            EXEC, FINAL, MEM1, MEM2: pipeline_advance = 1'b0;
        endcase
    end

    // Pass stays high through busy-wait, dropped by interrupt
    assign passExec = (state_q == EXEC) && issueCondPass && !interruptReq;
    assign condition_passed = passExec;

    // Main sequencing
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= IDLE;
        end
        else
        begin
            unique case (state_q)
                IDLE: if (clock_gate_enable && issueValid) state_q <= DECODE;
                DECODE: if (stepOk) state_q <= EXEC;
                EXEC:
                begin
                    // A refused or cancelled instruction leaves without further handshakes
                    if (!passExec || abortReq || decRefused_q)
                        state_q <= IDLE;
                    // Only Execute handshake counts here; earlier decode answers ignored
                    else if (execute_handshake == `HS_ABSENT)
                        state_q <= IDLE;
                    else if (execute_handshake == `HS_LAST)
                        state_q <= (op_q == OP_PAIR_TO_CP || op_q == OP_PAIR_FROM_CP)
                            ? FINAL : (op_q == OP_DATA_OP ? IDLE : MEM1);
                end
                FINAL: state_q <= MEM1;
                MEM1: state_q <= (op_q == OP_PAIR_TO_CP || op_q == OP_PAIR_FROM_CP)
                    ? MEM2 : IDLE;
                MEM2: state_q <= IDLE;
            endcase
        end
    end

    // Capture opcode and coprocessor number at Decode entry, source data at Execute entry
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            op_q <= OP_DATA_OP;
            cpNum_q <= 4'h0;
            srcA_q <= '0;
            srcB_q <= '0;
        end
        else if (state_q == IDLE && clock_gate_enable && issueValid)
        begin
            op_q <= issueOp;
            cpNum_q <= issueCpNum;
        end
        else if (state_q == DECODE && stepOk)
        begin
            srcA_q <= issueSrcA;
            srcB_q <= issueSrcB;
        end
    end

    // Decode refusal is kept so the trap is taken once, not again in Execute
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            decRefused_q <= 1'b0;
        else if (state_q == DECODE && stepOk)
            decRefused_q <= (decode_handshake == `HS_ABSENT);
    end

    // Write data: single word in MEM1 after commit, pair in FINAL then MEM1
    always_comb
    begin
        write_data_bus = '0;
        if (op_q == OP_TO_CP && state_q == MEM1)
            write_data_bus = srcA_q;
        else if (op_q == OP_PAIR_TO_CP && state_q == FINAL)
            write_data_bus = srcA_q;
        else if (op_q == OP_PAIR_TO_CP && state_q == MEM1)
            write_data_bus = srcB_q;
    end

    // System control coprocessor takes data over the address buses on GO
    always_comb
    begin
        fetch_addr_bus = '0;
        operand_addr_bus = '0;
        if (passExec && op_q == OP_TO_CP && cpNum_q == `SYSCTL_CP_NUM
            && execute_handshake == `HS_GO)
        begin
            fetch_addr_bus = srcA_q;
            operand_addr_bus = srcA_q;
        end
    end

    // Read data capture at end of Memory / second Execute
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdLo_q <= '0;
            rdHi_q <= '0;
        end
        else if (op_q == OP_FROM_CP && state_q == MEM1)
            rdLo_q <= read_data_bus;
        else if (op_q == OP_PAIR_FROM_CP && state_q == FINAL)
            rdLo_q <= read_data_bus;
        else if (op_q == OP_PAIR_FROM_CP && state_q == MEM1)
            rdHi_q <= read_data_bus;
    end

    // Register writeback: single move-from at the MEM1 sample, pair one cycle after the last sample
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            resultValid <= 1'b0;
            resultPair <= 1'b0;
            resultLo <= '0;
            resultHi <= '0;
        end
        else
        begin
            resultValid <= (state_q == MEM1 && op_q == OP_FROM_CP)
                || (state_q == MEM2 && op_q == OP_PAIR_FROM_CP);
            resultPair <= (state_q == MEM2 && op_q == OP_PAIR_FROM_CP);
            // Single move-from takes the bus word directly; the sample register lags a cycle
            resultLo <= (state_q == MEM1 && op_q == OP_FROM_CP)
                ? read_data_bus : rdLo_q;
            resultHi <= rdHi_q;
        end
    end

    // Abort is registered so it lands in the cycle after first Execute
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            abort_pending_cp <= 1'b0;
        else
            abort_pending_cp <= abortReq;
    end

    // Undefined trap: ABSENT at Execute entry or in busy-wait, or undefined opcode
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            undefTrap <= 1'b0;
        else
            undefTrap <= (state_q == DECODE && stepOk && issueCondPass
                    && decode_handshake == `HS_ABSENT)
                || (passExec && !decRefused_q && execute_handshake == `HS_ABSENT)
                || (state_q == IDLE && issueValid && archUndefined);
    end

    assign cpBusy = (state_q != IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_PASS_ONLY_EXEC: assert property (@(posedge clk) disable iff (!reset_n)
        condition_passed |-> state_q == EXEC)
        else $error("pass outside Execute");
    AST_IRQ_DROPS_PASS: assert property (@(posedge clk) disable iff (!reset_n)
        interruptReq |-> !condition_passed)
        else $error("pass high during interrupt");
    AST_ABORT_LATE: assert property (@(posedge clk) disable iff (!reset_n)
        abortReq |=> abort_pending_cp)
        else $error("abort not registered");
    AST_PAIR_WDATA: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == FINAL && op_q == OP_PAIR_TO_CP) |-> write_data_bus == srcA_q
        ##1 write_data_bus == srcB_q)
        else $error("pair write order wrong");
    AST_PAIR_RESULT: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == MEM2 && op_q == OP_PAIR_FROM_CP) |=> resultValid && resultPair)
        else $error("pair result missing");
    AST_INTERLOCK: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == DECODE && isTo && !issueSrcReady) |=> state_q == DECODE)
        else $error("interlock ignored");
    AST_SYSCTL_ADDR: assert property (@(posedge clk) disable iff (!reset_n)
        (fetch_addr_bus != '0) |-> execute_handshake == `HS_GO && cpNum_q == `SYSCTL_CP_NUM)
        else $error("address bus data without GO");
    AST_LAST_COMMIT: assert property (@(posedge clk) disable iff (!reset_n)
        (passExec && !abortReq && !decRefused_q && op_q == OP_FROM_CP
            && execute_handshake == `HS_LAST)
        |=> ##1 resultValid)
        else $error("move-from not committed");
    AST_ADV_GATED: assert property (@(posedge clk) disable iff (!reset_n)
        pipeline_advance |-> clock_gate_enable)
        else $error("advance without enable");
endmodule : coprocessor_handshake_port

// ### test/cp_model.sv
// Behavioural coprocessor on the far side of the handshake port.
// Assumes the bench sets the answer levels before each issue.
`timescale 1ns/1ps
`include "cp_port_cfg.svh"
module cp_model
    import cp_port_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clock_gate_enable,
    input wire logic pipeline_advance,
    input wire logic condition_passed,
    input wire cp_port_pkg::handshake_t decAns,
    input wire cp_port_pkg::handshake_t fillAns,
    input wire cp_port_pkg::handshake_t endAns,
    input wire logic [3:0] fillCnt,
    input wire logic [31:0] wordLo,
    input wire logic [31:0] wordHi,
    output cp_port_pkg::handshake_t decode_handshake,
    output cp_port_pkg::handshake_t execute_handshake,
    output logic [31:0] read_data_bus
);
    // A second coprocessor that answers ABSENT shares the buses and must not disturb them
    localparam handshake_t otherAns = `HS_ABSENT;
    logic [3:0] execCnt_q;
    logic [1:0] after_q;
    logic [31:0] idle_q;
    logic decValid_q;
    logic exeValid_q;
    handshake_t ownExec;
    // Follower steps only with the core, so a stalled core leaves it frozen
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            decValid_q <= 1'b0;
            exeValid_q <= 1'b0;
        end
        else if (clock_gate_enable && pipeline_advance)
        begin
            decValid_q <= !decValid_q;
            exeValid_q <= decValid_q;
        end
    end
    // Count restarts while pass is low, so an abandoned wait is forgotten
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            execCnt_q <= 4'h0;
            after_q <= 2'h0;
            idle_q <= 32'ha5a5_5a5a;
        end
        else
        begin
            execCnt_q <= (condition_passed && exeValid_q)
                ? execCnt_q + 4'h1 : 4'h0;
            after_q <= {after_q[0],
                condition_passed && exeValid_q && execute_handshake == `HS_LAST};
            idle_q <= ~read_data_bus;
        end
    end
    // Decode answer is a level from the bench; fills come before the final answer
    assign ownExec = (execCnt_q < fillCnt) ? fillAns : endAns;
    // Bit 1 of all coprocessors is ANDed and bit 0 ORed before reaching the core
    assign decode_handshake = {decAns[1] & otherAns[1],
        decAns[0] | otherAns[0]};
    assign execute_handshake = {ownExec[1] & otherAns[1],
        ownExec[0] | otherAns[0]};
    // Select is registered on the rising clock; a released bus never repeats itself
    assign read_data_bus = (after_q != 2'h0)
        ? (after_q[0] ? wordLo : wordHi) : idle_q;
endmodule : cp_model

// ### test/coprocessor_handshake_port_bench.sv
// Self-checking bench for the core-side coprocessor handshake port.
// Assumes cp_model is the far-side coprocessor; all ports join by name.
`timescale 1ns/1ps
`include "cp_port_cfg.svh"
module coprocessor_handshake_port_bench;
    import cp_port_pkg::*;
    localparam handshake_t hsW = `HS_WAIT, hsG = `HS_GO, hsL = `HS_LAST, hsA = `HS_ABSENT;
    localparam int WatchNs = 100000;
    logic clk = 1'b0, reset_n = 1'b0, clock_gate_enable = 1'b1, issueValid = 1'b0;
    logic issueCondPass = 1'b0, issueSrcReady = 1'b1, archUndefined = 1'b0;
    logic interruptReq = 1'b0, abortReq = 1'b0, abortSeen = 1'b0;
    cp_op_e issueOp = OP_DATA_OP;
    logic [3:0] issueCpNum = 4'h0, fillCnt = 4'h0;
    logic [31:0] issueSrcA = 32'h0, issueSrcB = 32'h0, wordLo = 32'h0, wordHi = 32'h0;
    logic [31:0] seed = 32'h54, read_data_bus, write_data_bus, fetch_addr_bus;
    logic [31:0] operand_addr_bus, resultLo, resultHi;
    handshake_t decAns = hsA, fillAns = hsW, endAns = hsL, decode_handshake, execute_handshake;
    logic pipeline_advance, condition_passed, abort_pending_cp;
    logic undefTrap, cpBusy, resultValid, resultPair;
    int n_fail = 0, compares = 0;
    coprocessor_handshake_port coprocessor_handshake_port_inst (.*);
    cp_model cp_model_inst (.*);
    // 100 MHz clock
    always #5 clk = ~clk;
    // Shift register with a fixed start, so every run sees the same values
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsrNext
    // One compare for every result; single bits arrive zero-extended
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic stop_test;
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    // Cancel output must follow its request by exactly one clock
    always @(negedge clk)
    begin
        if (reset_n)
            chk(32'(abort_pending_cp), 32'(abortSeen));
        abortSeen = abortReq;
    end
    // One instruction from issue to retirement, watched at every falling edge
    task automatic runOp(input cp_op_e op, input logic [3:0] cp, input int cond,
        input handshake_t dec, input handshake_t fill, input int fillN,
        input handshake_t endA, input int irq, input int stall);
        int nRes = 0, nTrap = 0, nPass = 0, nAdv = 0, after = 0;
        logic isTo, expTrap;
        isTo = (op == OP_TO_CP) || (op == OP_PAIR_TO_CP);
        expTrap = ((cond != 0) && (irq == 0) && (dec == hsA || endA == hsA))
            || (op == OP_DATA_OP && cond == 0);
        seed = lfsrNext(seed);
        @(posedge clk);
        abortReq <= seed[2]; // Random cancel with nothing in flight
        interruptReq <= 1'b0;
        clock_gate_enable <= 1'b1;
        @(posedge clk);
        abortReq <= 1'b0;
        archUndefined <= (op == OP_DATA_OP) && (cond == 0);
        issueOp <= op;
        {issueValid, issueCpNum, issueCondPass, issueSrcReady} <= {1'b1, cp, cond != 0, stall == 0};
        {issueSrcA, issueSrcB, wordLo, wordHi} <=
            {seed, ~seed, seed ^ 32'h0f0f_0f0f, ~{seed[7:0], seed[31:8]}};
        {decAns, fillAns, fillCnt, endAns} <= {dec, fill, 4'(fillN), endA};
        for (int k = 1; k < 16 + fillN; k++)
        begin
            @(negedge clk);
            if (pipeline_advance && nAdv == 1 && isTo)
                chk(32'(issueSrcReady), 32'h1);
            nAdv += 32'(pipeline_advance);
            if (after == 1 && isTo)
                chk(write_data_bus, issueSrcA);
            if (after == 2 && op == OP_PAIR_TO_CP)
                chk(write_data_bus, issueSrcB);
            if (op == OP_TO_CP && cp == `SYSCTL_CP_NUM && condition_passed && execute_handshake == hsG)
            begin
                chk(fetch_addr_bus, issueSrcA);
                chk(operand_addr_bus, issueSrcA);
            end
            if (resultValid)
            begin
                nRes++;
                chk(resultLo, wordLo);
                chk(32'(resultPair), 32'(op == OP_PAIR_FROM_CP));
                if (op == OP_PAIR_FROM_CP)
                    chk(resultHi, wordHi);
            end
            if (interruptReq)
                chk(32'(condition_passed), 32'h0);
            nTrap += 32'(undefTrap);
            nPass += 32'(condition_passed);
            if (after > 0 || (condition_passed && execute_handshake == hsL))
                after++;
            @(posedge clk);
            if (nAdv > 0)
                issueValid <= 1'b0;
            issueSrcReady <= (k >= stall);
            interruptReq <= (irq == 1) && (nPass > 1);
            abortReq <= (irq == 2) && (nPass == 1);
            clock_gate_enable <= (k % 4 != 3) || seed[4];
        end
        @(negedge clk);
        chk(32'(nRes), 32'(!expTrap && cond != 0 && irq == 0 && !isTo && op != OP_DATA_OP));
        chk(32'(nTrap), 32'(expTrap));
        chk(32'(nPass > 0), 32'(cond != 0));
        chk(32'(cpBusy), 32'h0);
    endtask : runOp
    // Corner cases first, then a random mix of operations
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        runOp(OP_FROM_CP, 4'h1, 1, hsG, hsW, 0, hsL, 0, 0);
        runOp(OP_TO_CP, 4'h2, 1, hsG, hsW, 1, hsL, 0, 3);
        runOp(OP_PAIR_TO_CP, 4'h3, 1, hsG, hsW, 2, hsL, 0, 2);
        runOp(OP_PAIR_FROM_CP, 4'h4, 1, hsG, hsW, 0, hsL, 0, 0);
        runOp(OP_DATA_OP, 4'h5, 1, hsL, hsW, 0, hsL, 0, 0);
        runOp(OP_DATA_OP, 4'h5, 1, hsW, hsW, 3, hsL, 0, 0);
        runOp(OP_DATA_OP, 4'h6, 1, hsA, hsA, 0, hsA, 0, 0);
        runOp(OP_FROM_CP, 4'h7, 1, hsW, hsW, 2, hsA, 0, 0);
        runOp(OP_TO_CP, `SYSCTL_CP_NUM, 1, hsG, hsG, 3, hsL, 0, 0);
        runOp(OP_DATA_OP, 4'h8, 0, hsA, hsA, 0, hsA, 0, 0);
        runOp(OP_DATA_OP, 4'h9, 1, hsW, hsW, 5, hsL, 1, 0);
        runOp(OP_FROM_CP, 4'ha, 1, hsG, hsW, 2, hsL, 2, 0);
        for (int i = 0; i < 30; i++)
            runOp(cp_op_e'(3'(seed % 5)), seed[11:8], int'(seed[5] | seed[6]), hsG, hsW,
                int'(seed[1:0]), hsL, 0, int'(seed[3:2]));
        stop_test();
    end
    // A hang counts as a mismatch and ends the run the normal way
    initial
    begin
        #WatchNs;
        n_fail++;
        stop_test();
    end
endmodule : coprocessor_handshake_port_bench
